// ---- tap_pkg.sv ----
// Purpose: shared constants and types for the test access port and its debugger end
// Assumes: both ends compile against this package
// Notes:   instruction codes and lengths are the values the link carries

package tap_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// controller states, binary codes written out
	typedef enum logic [3:0] {
		ST_RESET      = 4'h0,
		ST_IDLE       = 4'h1,
		ST_SEL_DR     = 4'h2,
		ST_CAPTURE_DR = 4'h3,
		ST_SHIFT_DR   = 4'h4,
		ST_EXIT1_DR   = 4'h5,
		ST_PAUSE_DR   = 4'h6,
		ST_EXIT2_DR   = 4'h7,
		ST_UPDATE_DR  = 4'h8,
		ST_SEL_IR     = 4'h9,
		ST_CAPTURE_IR = 4'hA,
		ST_SHIFT_IR   = 4'hB,
		ST_EXIT1_IR   = 4'hC,
		ST_PAUSE_IR   = 4'hD,
		ST_EXIT2_IR   = 4'hE,
		ST_UPDATE_IR  = 4'hF
	} tap_state_t;

	typedef enum logic [1:0] {
		CMD_RESET = 2'h0,
		CMD_IR    = 2'h1,
		CMD_DR    = 2'h2
	} cmd_kind_t;

	////////////////////////////////////////////////////////////////////////////////
	// instruction register
	localparam int         IR_W          = 4;
	localparam logic [3:0] IR_CAPTURE    = 4'h1;
	localparam logic [3:0] INSTR_BYPASS  = 4'hF;
	localparam logic [3:0] DEBUG_INSTR_0 = 4'h8;
	localparam logic [3:0] DEBUG_INSTR_1 = 4'h9;
	localparam logic [3:0] DEBUG_INSTR_2 = 4'hA;
	localparam logic [3:0] DEBUG_INSTR_3 = 4'hB;

	// data path lengths
	localparam int         DR_W          = 18;
	localparam logic [4:0] LEN_BYPASS    = 5'h01;
	localparam logic [4:0] LEN_BP_ADDR   = 5'h12;
	localparam logic [4:0] LEN_BYTE      = 5'h08;

	// breakpoint unit
	localparam int         BP_N          = 4;
	localparam int         ADDR_W        = 16;
	localparam int         PKT_W         = 20;
	localparam int         CTL_FLOW      = 0;
	localparam int         CTL_STEP      = 1;
	localparam int         CTL_COMB_DATA = 2;
	localparam int         CTL_RANGE     = 4;
	localparam int         CTL_BP_EN     = 5;
	localparam logic [7:0] CTL_RESET     = 8'h00;
	localparam int         CMD_RESUME    = 0;

	////////////////////////////////////////////////////////////////////////////////
	// link timing, debugger end
	localparam int         SYS_CLK_NS    = 25;
	localparam int         TCK_HALF_NS   = 100;
	localparam int         TCK_HALF_CYC  = (TCK_HALF_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
	localparam int         RESET_EDGES   = 5;
	localparam int         SEQ_W         = 24;
	localparam logic [4:0] PRE_IR        = 5'h04;
	localparam logic [4:0] PRE_DR        = 5'h03;
	localparam logic [4:0] TAIL_EDGES    = 5'h02;

endpackage : tap_pkg

// ---- tap_link_if.sv ----
// Purpose: four-wire test link plus the shared system reset line
// Assumes: debugger end makes the link clock
// Notes:   tdo idles high through the pull-up when the device does not drive it

`timescale 1ns/10ps

interface tap_link_if (
	input wire logic ext_rst_n
);
	logic tck;
	logic tms;
	logic tdi;
	logic tdo_out;
	logic tdo_oe;
	logic tdo;
	logic rst_oe;
	logic rst_line_n;

	assign tdo        = tdo_oe ? tdo_out : 1'b1;
	// open-collector reset line: anyone may pull it low
	assign rst_line_n = ext_rst_n & ~rst_oe;

	modport device (input tck, input tms, input tdi, output tdo_out, output tdo_oe);
	modport host   (output tck, output tms, output tdi, output rst_oe,
	                input tdo, input rst_line_n);
endinterface : tap_link_if

// ---- tap_device.sv ----
// Purpose: test access port controller with debug gate and breakpoint unit
// Assumes: link clock from the debugger; system side on CLK_SYS
// Notes:   debug writes cross to CLK_SYS by toggle; status returns as levels
//
// Behaviour
// - sixteen-state controller steered by tms per tck
// - power-on reset starts in logic reset
// - five tms-high clocks always reach reset
// - all shift paths move lsb first
// - debugger uses 1,1,0,0 to reach shift-ir
// - debugger raises tms with last instruction bit
// - instruction capture value shifted out is 0x01
// - instruction latched only in update-ir
// - instruction selects the data path
// - debugger uses 1,0,0 to reach shift-dr
// - shift-dr outputs captured parallel values
// - latched data outputs change only in update-dr
// - exit and pause states take no action
// - fuse unprogrammed: plain pins, controller held reset
// - fuse programmed: pull-ups on, port enabled
// - port enabled needs fuse and clear disable bit
// - debug needs debug fuse and no lock
// - codes 0x8 to 0xB open debug paths
// - break on flow change and single step
// - two program plus two combined breakpoints
// - no test-reset input on the port
// - debugger watches and may pull system reset

`timescale 1ns/10ps

module tap_device import tap_pkg::*; (
	// link
	tap_link_if.device            link,
	// system clock and reset
	input  wire logic             CLK_SYS,
	input  wire logic             RESETN,
	// configuration
	input  wire logic             TEST_PORT_ENABLE_FUSE,
	input  wire logic             TEST_PORT_DISABLE_BIT,
	input  wire logic             DEBUG_ENABLE_FUSE,
	input  wire logic             SECURITY_LOCK_BIT_ONE,
	input  wire logic             SECURITY_LOCK_BIT_TWO,
	// cpu trace
	input  wire logic             PC_FETCH,
	input  wire logic [ADDR_W-1:0] PC,
	input  wire logic             FLOW_CHANGE,
	input  wire logic             STEP_DONE,
	input  wire logic             DATA_ACCESS,
	input  wire logic [ADDR_W-1:0] DATA_ADDR,
	// status
	output logic                  TAP_PINS_ACTIVE,
	output logic                  TAP_PULLUP_EN,
	output logic                  DEBUG_ACTIVE,
	output logic                  BREAK_REQ
);

	////////////////////////////////////////////////////////////////////////////////
	// functions

	function automatic tap_state_t tap_next(input tap_state_t s, input logic tms);
		case (s)
			ST_RESET:      tap_next = tms ? ST_RESET    : ST_IDLE;
			ST_IDLE:       tap_next = tms ? ST_SEL_DR   : ST_IDLE;
			ST_SEL_DR:     tap_next = tms ? ST_SEL_IR   : ST_CAPTURE_DR;
			ST_CAPTURE_DR: tap_next = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
			ST_SHIFT_DR:   tap_next = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
			ST_EXIT1_DR:   tap_next = tms ? ST_UPDATE_DR : ST_PAUSE_DR;
			ST_PAUSE_DR:   tap_next = tms ? ST_EXIT2_DR : ST_PAUSE_DR;
			ST_EXIT2_DR:   tap_next = tms ? ST_UPDATE_DR : ST_SHIFT_DR;
			ST_UPDATE_DR:  tap_next = tms ? ST_SEL_DR   : ST_IDLE;
			ST_SEL_IR:     tap_next = tms ? ST_RESET    : ST_CAPTURE_IR;
			ST_CAPTURE_IR: tap_next = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
			ST_SHIFT_IR:   tap_next = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
			ST_EXIT1_IR:   tap_next = tms ? ST_UPDATE_IR : ST_PAUSE_IR;
			ST_PAUSE_IR:   tap_next = tms ? ST_EXIT2_IR : ST_PAUSE_IR;
			ST_EXIT2_IR:   tap_next = tms ? ST_UPDATE_IR : ST_SHIFT_IR;
			ST_UPDATE_IR:  tap_next = tms ? ST_SEL_DR   : ST_IDLE;
			default:       tap_next = ST_RESET;
		endcase
	endfunction : tap_next

	// tdi enters at the top of the selected length, bit 0 leaves first
	function automatic logic [DR_W-1:0] shift_in(input logic [DR_W-1:0] r, input logic d,
		input logic [4:0] len);
		logic [DR_W-1:0] v;
		v = {1'b0, r[DR_W-1:1]};
		v[len - 5'h01] = d;
		shift_in = v;
	endfunction : shift_in

	function automatic logic is_debug(input logic [IR_W-1:0] i);
		is_debug = (i[3:2] == DEBUG_INSTR_0[3:2]);
	endfunction : is_debug

	////////////////////////////////////////////////////////////////////////////////
	// system domain: port and debug enables

	logic                en_reg, dbg_ok_reg, pullup_reg;

	always_ff @(posedge CLK_SYS)
	begin
		if (!RESETN)
		begin
			en_reg     <= 1'b0;
			dbg_ok_reg <= 1'b0;
			pullup_reg <= 1'b0;
		end
		else
		begin
			en_reg     <= TEST_PORT_ENABLE_FUSE & ~TEST_PORT_DISABLE_BIT;
			pullup_reg <= TEST_PORT_ENABLE_FUSE;
			dbg_ok_reg <= TEST_PORT_ENABLE_FUSE & ~TEST_PORT_DISABLE_BIT & DEBUG_ENABLE_FUSE
				& ~SECURITY_LOCK_BIT_ONE & ~SECURITY_LOCK_BIT_TWO;
		end
	end

	assign TAP_PINS_ACTIVE = en_reg;
	assign TAP_PULLUP_EN   = pullup_reg;
	assign DEBUG_ACTIVE    = dbg_ok_reg;

	////////////////////////////////////////////////////////////////////////////////
	// link domain: synchronisers from the system side

	logic                en_s1, en_s2, ok_s1, ok_s2, hit_s1, hit_s2;
	logic                hit_reg;

	always_ff @(posedge link.tck)
	begin
		en_s1  <= en_reg;
		en_s2  <= en_s1;
		ok_s1  <= dbg_ok_reg;
		ok_s2  <= ok_s1;
		hit_s1 <= hit_reg;
		hit_s2 <= hit_s1;
	end

	////////////////////////////////////////////////////////////////////////////////
	// link domain: controller and shift paths

	tap_state_t          state_reg;
	logic [IR_W-1:0]     ir_reg, ir_shift_reg;
	logic [DR_W-1:0]     dr_shift_reg;
	logic                tdo_reg, tdo_oe_reg;
	logic [7:0]          ctl_tck_reg;
	logic [PKT_W-1:0]    pkt_reg;
	logic                pkt_tgl_reg;

	// debug paths fall back to bypass while debug is locked out
	wire  logic [IR_W-1:0] instr    = (is_debug(ir_reg) && ok_s2) ? ir_reg : INSTR_BYPASS;
	wire  tap_state_t      state_next = tap_next(state_reg, link.tms);
	wire  logic [4:0]      dr_len   = (instr == DEBUG_INSTR_0) ? LEN_BP_ADDR :
	                                  is_debug(instr) ? LEN_BYTE : LEN_BYPASS;
	wire  logic [DR_W-1:0] dr_capture = (instr == DEBUG_INSTR_1) ? {10'h000, ctl_tck_reg} :
	                                    (instr == DEBUG_INSTR_2) ? {16'h0000, hit_s2, ok_s2} :
	                                    {DR_W{1'b0}};
	wire  logic [DR_W-1:0] dr_shifted = shift_in(dr_shift_reg, link.tdi, dr_len);
	wire  logic [IR_W-1:0] ir_shifted = {link.tdi, ir_shift_reg[IR_W-1:1]};

	// a cleared enable holds the controller in reset; no test-reset pin exists
	always_ff @(posedge link.tck)
	begin
		if (!en_s2)
			state_reg <= ST_RESET;
		else
			state_reg <= state_next;
	end

	always_ff @(posedge link.tck)
	begin
		if (!en_s2 || state_reg == ST_RESET)
			ir_reg <= INSTR_BYPASS;
		else if (state_reg == ST_UPDATE_IR)
			ir_reg <= ir_shift_reg;
	end

	// exit and pause states leave both shift registers below untouched; tdo_reg is set to 1
	always_ff @(posedge link.tck)
	begin
		case (state_reg)
			ST_CAPTURE_IR: ir_shift_reg <= IR_CAPTURE;
			ST_SHIFT_IR:   ir_shift_reg <= ir_shifted;
			default:       ir_shift_reg <= ir_shift_reg;
		endcase
	end

	always_ff @(posedge link.tck)
	begin
		case (state_reg)
			ST_CAPTURE_DR: dr_shift_reg <= dr_capture;
			ST_SHIFT_DR:   dr_shift_reg <= dr_shifted;
			default:       dr_shift_reg <= dr_shift_reg;
		endcase
	end

	always_ff @(posedge link.tck)
	begin
		case (state_reg)
			ST_CAPTURE_IR: tdo_reg <= IR_CAPTURE[0];
			ST_SHIFT_IR:   tdo_reg <= ir_shifted[0];
			ST_CAPTURE_DR: tdo_reg <= dr_capture[0];
			ST_SHIFT_DR:   tdo_reg <= dr_shifted[0];
			default:       tdo_reg <= 1'b1;
		endcase
		tdo_oe_reg <= en_s2 & (state_next == ST_SHIFT_IR || state_next == ST_SHIFT_DR);
	end

	assign link.tdo_out = tdo_reg;
	assign link.tdo_oe  = tdo_oe_reg;

	// the packet stays still until the next update, so the far side may sample it late
	always_ff @(posedge link.tck)
	begin
		if (!en_s2)
		begin
			ctl_tck_reg <= CTL_RESET;
			pkt_reg     <= {PKT_W{1'b0}};
			pkt_tgl_reg <= 1'b0;
		end
		else if (state_reg == ST_UPDATE_DR && is_debug(instr) && instr != DEBUG_INSTR_2)
		begin
			pkt_reg     <= {instr[1:0], dr_shift_reg};
			pkt_tgl_reg <= ~pkt_tgl_reg;
			if (instr == DEBUG_INSTR_1)
				ctl_tck_reg <= dr_shift_reg[7:0];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// system domain: packet receive and breakpoint unit

	logic                tgl_s1, tgl_s2, tgl_s3;
	logic [ADDR_W-1:0]   bp_addr_reg [BP_N];
	logic [7:0]          ctl_reg;
	logic [BP_N-1:0]     bp_hit;

	wire  logic          pkt_take = tgl_s2 ^ tgl_s3;
	wire  logic [1:0]    pkt_kind = pkt_reg[PKT_W-1:PKT_W-2];
	wire  logic [1:0]    pkt_idx  = pkt_reg[ADDR_W+1:ADDR_W];

	always_ff @(posedge CLK_SYS)
	begin
		tgl_s1 <= pkt_tgl_reg;
		tgl_s2 <= tgl_s1;
		tgl_s3 <= tgl_s2;
	end

	always_ff @(posedge CLK_SYS)
	begin
		if (!RESETN)
			ctl_reg <= CTL_RESET;
		else if (pkt_take && pkt_kind == DEBUG_INSTR_1[1:0])
			ctl_reg <= pkt_reg[7:0];
	end

	always_ff @(posedge CLK_SYS)
	begin
		if (!RESETN)
			bp_addr_reg <= '{default: {ADDR_W{1'b0}}};
		else if (pkt_take && pkt_kind == DEBUG_INSTR_0[1:0])
			bp_addr_reg[pkt_idx] <= pkt_reg[ADDR_W-1:0];
	end

	// slots 0 and 1 watch program fetches; 2 and 3 watch either space, or form one range
	generate
		for (genvar i = 0; i < BP_N; i++)
		begin : g_bp
			wire logic              data_sp = (i >= 2) &&
				ctl_reg[(i == 3 && !ctl_reg[CTL_RANGE]) ? CTL_COMB_DATA + 1 : CTL_COMB_DATA];
			wire logic [ADDR_W-1:0] addr    = data_sp ? DATA_ADDR : PC;
			wire logic              strobe  = data_sp ? DATA_ACCESS : PC_FETCH;
			wire logic [ADDR_W-1:0] mask    = (i == 2 && ctl_reg[CTL_RANGE]) ?
				bp_addr_reg[3] : {ADDR_W{1'b1}};
			wire logic              usable  = !(i == 3 && ctl_reg[CTL_RANGE]);
			assign bp_hit[i] = usable & strobe & (((addr ^ bp_addr_reg[i]) & mask) == '0);
		end
	endgenerate

	wire  logic          brk_set = dbg_ok_reg & ((ctl_reg[CTL_BP_EN] & |bp_hit)
		| (ctl_reg[CTL_FLOW] & FLOW_CHANGE) | (ctl_reg[CTL_STEP] & STEP_DONE));
	wire  logic          brk_clr = pkt_take && pkt_kind == DEBUG_INSTR_3[1:0]
		&& pkt_reg[CMD_RESUME];

	// a break arriving with a resume is kept
	always_ff @(posedge CLK_SYS)
	begin
		if (!RESETN)
			hit_reg <= 1'b0;
		else
			hit_reg <= brk_set | (hit_reg & ~brk_clr);
	end

	assign BREAK_REQ = hit_reg;

endmodule : tap_device

// ---- tap_debugger.sv ----
// Purpose: debugger end that drives the link from simple scan commands
// Assumes: CLK_SYS at 40 MHz; link clock divided down from it
// Notes:   one command at a time; ends every scan in run-test/idle

`timescale 1ns/10ps

module tap_debugger import tap_pkg::*; (
	// link
	tap_link_if.host              link,
	// clock and reset
	input  wire logic             CLK_SYS,
	input  wire logic             RESETN,
	// command
	input  wire logic             CMD_VALID,
	input  wire cmd_kind_t        CMD_KIND,
	input  wire logic [4:0]       CMD_LEN,
	input  wire logic [DR_W-1:0]  CMD_DATA,
	output logic                  CMD_READY,
	// answer
	output logic                  RSP_VALID,
	output logic [DR_W-1:0]       RSP_DATA,
	// system reset line
	input  wire logic             SYS_RESET_REQ,
	output logic                  SYS_RESET_SEEN
);

	////////////////////////////////////////////////////////////////////////////////
	// sequence build

	logic [SEQ_W-1:0]    one_seq;
	assign one_seq = {{(SEQ_W-1){1'b0}}, 1'b1};

	wire  logic          is_rst   = (CMD_KIND == CMD_RESET);
	wire  logic          is_ir    = (CMD_KIND == CMD_IR);
	wire  logic [4:0]    pre      = is_rst ? 5'h00 : is_ir ? PRE_IR : PRE_DR;
	wire  logic [4:0]    len      = is_rst ? 5'h00 : is_ir ? 5'(IR_W) : CMD_LEN;
	// 1,1,0,0 to shift-ir or 1,0,0 to shift-dr, lsb first
	wire  logic [SEQ_W-1:0] pre_pat = is_ir ? 24'h000003 : 24'h000001;
	wire  logic [SEQ_W-1:0] tms_scan = pre_pat | (one_seq << (pre + len - 5'h01))
		| (one_seq << (pre + len));
	wire  logic [SEQ_W-1:0] tms_seq = is_rst ? ((one_seq << RESET_EDGES) - one_seq)
		: tms_scan;
	wire  logic [SEQ_W-1:0] tdi_seq = {6'h00, CMD_DATA} << pre;
	wire  logic [4:0]    total    = is_rst ? 5'(RESET_EDGES + 1) : pre + len + TAIL_EDGES;

	////////////////////////////////////////////////////////////////////////////////
	// link sequencer

	logic                ready_reg, tck_reg, tms_reg, tdi_reg, rsp_v_reg;
	logic [SEQ_W-1:0]    tms_sh_reg, tdi_sh_reg;
	logic [4:0]          step_reg, pre_reg, len_reg, total_reg;
	logic [7:0]          div_reg;
	logic [DR_W-1:0]     rx_reg, rsp_reg;
	logic                tdo_s1, tdo_s2, rst_s1, rst_s2, seen_reg, rst_oe_reg;

	wire  logic          half_done = (div_reg == 8'(TCK_HALF_CYC - 1));
	wire  logic [4:0]    bit_idx   = step_reg - pre_reg;
	wire  logic          in_window = (step_reg >= pre_reg) && (bit_idx < len_reg);

	always_ff @(posedge CLK_SYS)
	begin
		tdo_s1 <= link.tdo;
		tdo_s2 <= tdo_s1;
		rst_s1 <= link.rst_line_n;
		rst_s2 <= rst_s1;
	end

	always_ff @(posedge CLK_SYS)
	begin
		if (!RESETN)
		begin
			ready_reg <= 1'b1;
			tck_reg   <= 1'b0;
			tms_reg   <= 1'b1;
			tdi_reg   <= 1'b0;
			div_reg   <= 8'h00;
			step_reg  <= 5'h00;
			rsp_v_reg <= 1'b0;
		end
		else
		begin
			rsp_v_reg <= 1'b0;
			if (ready_reg && CMD_VALID)
			begin
				ready_reg  <= 1'b0;
				tms_sh_reg <= tms_seq;
				tdi_sh_reg <= tdi_seq;
				tms_reg    <= tms_seq[0];
				tdi_reg    <= tdi_seq[0];
				pre_reg    <= pre;
				len_reg    <= len;
				total_reg  <= total;
				step_reg   <= 5'h00;
				div_reg    <= 8'h00;
			end
			else if (!ready_reg && !half_done)
				div_reg <= div_reg + 8'h01;
			else if (!ready_reg)
			begin
				div_reg <= 8'h00;
				tck_reg <= ~tck_reg;
				// rising edge: tdo has stood since the previous rise
				if (!tck_reg && in_window)
					rx_reg[bit_idx] <= tdo_s2;
				if (tck_reg && step_reg == total_reg - 5'h01)
				begin
					ready_reg <= 1'b1;
					rsp_v_reg <= 1'b1;
					rsp_reg   <= rx_reg;
					tms_reg   <= 1'b0;
				end
				else if (tck_reg)
				begin
					step_reg   <= step_reg + 5'h01;
					tms_reg    <= tms_sh_reg[1];
					tdi_reg    <= tdi_sh_reg[1];
					tms_sh_reg <= tms_sh_reg >> 1;
					tdi_sh_reg <= tdi_sh_reg >> 1;
				end
			end
		end
	end

	// reset line is watched and may be pulled low, never driven high
	always_ff @(posedge CLK_SYS)
	begin
		if (!RESETN)
		begin
			seen_reg   <= 1'b0;
			rst_oe_reg <= 1'b0;
		end
		else
		begin
			seen_reg   <= ~rst_s2;
			rst_oe_reg <= SYS_RESET_REQ;
		end
	end

	assign link.tck       = tck_reg;
	assign link.tms       = tms_reg;
	assign link.tdi       = tdi_reg;
	assign link.rst_oe    = rst_oe_reg;
	assign CMD_READY      = ready_reg;
	assign RSP_VALID      = rsp_v_reg;
	assign RSP_DATA       = rsp_reg;
	assign SYS_RESET_SEEN = seen_reg;

endmodule : tap_debugger

// ---- tap_link_properties.sv ----
// Purpose: concurrent checks on the link between debugger and device
// Assumes: tck comes from the debugger, divided from CLK_SYS
// Notes:   the local controller copy is trusted only after five tms-high edges

`timescale 1ns/10ps

module tap_link_properties import tap_pkg::*; (
	// system side
	input wire logic CLK_SYS,
	input wire logic RESETN,
	// link
	input wire logic tck,
	input wire logic tms,
	input wire logic tdi,
	input wire logic tdo_out,
	input wire logic tdo_oe,
	input wire logic tdo,
	input wire logic rst_oe,
	input wire logic rst_line_n
);
	////////////////////////////////////////////////////////////////////////////////
	function automatic tap_state_t nxt(input tap_state_t s, input logic m);
		case (s)
			ST_RESET: return m ? ST_RESET : ST_IDLE;
			ST_IDLE, ST_UPDATE_DR, ST_UPDATE_IR: return m ? ST_SEL_DR : ST_IDLE;
			ST_SEL_DR: return m ? ST_SEL_IR : ST_CAPTURE_DR;
			ST_CAPTURE_DR, ST_SHIFT_DR: return m ? ST_EXIT1_DR : ST_SHIFT_DR;
			ST_EXIT1_DR: return m ? ST_UPDATE_DR : ST_PAUSE_DR;
			ST_PAUSE_DR: return m ? ST_EXIT2_DR : ST_PAUSE_DR;
			ST_EXIT2_DR: return m ? ST_UPDATE_DR : ST_SHIFT_DR;
			ST_SEL_IR: return m ? ST_RESET : ST_CAPTURE_IR;
			ST_CAPTURE_IR, ST_SHIFT_IR: return m ? ST_EXIT1_IR : ST_SHIFT_IR;
			ST_EXIT1_IR: return m ? ST_UPDATE_IR : ST_PAUSE_IR;
			ST_PAUSE_IR: return m ? ST_EXIT2_IR : ST_PAUSE_IR;
			ST_EXIT2_IR: return m ? ST_UPDATE_IR : ST_SHIFT_IR;
			default: return ST_RESET;
		endcase
	endfunction : nxt

	// the link has no reset, so the copy starts blind and syncs on five highs
	tap_state_t st_reg    = ST_RESET;
	tap_state_t st_next;
	logic [2:0] hi_reg    = 3'h0;
	logic [2:0] hi_next;
	logic       known_reg = 1'b0;
	logic       known_next;
	logic       ir_first;
	logic       ir_later;

	assign st_next    = nxt(st_reg, tms);
	assign hi_next    = tms ? ((hi_reg == 3'h5) ? 3'h5 : hi_reg + 3'h1) : 3'h0;
	assign known_next = known_reg | (hi_next == 3'h5);
	assign ir_first   = known_reg && tdo_oe && st_reg == ST_SHIFT_IR;

	always_ff @(posedge tck)
	begin
		st_reg    <= st_next;
		hi_reg    <= hi_next;
		known_reg <= known_next;
	end

	////////////////////////////////////////////////////////////////////////////////
	a_tck_high_time: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
		$rose(tck) |-> tck [*4] ##1 !tck) else $error("tck high time wrong");
	a_tms_on_fall: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
		$changed(tms) |-> !tck) else $error("tms moved while tck high");
	a_tdi_on_fall: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
		$changed(tdi) |-> !tck) else $error("tdi moved while tck high");
	a_reset_line_pull: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
		rst_oe |-> !rst_line_n) else $error("reset line not pulled");
	a_tdo_pull_up: assert property (@(posedge tck) disable iff (!RESETN)
		!tdo_oe |-> tdo) else $error("released tdo not high");
	a_tdo_only_shift: assert property (@(posedge tck) disable iff (!RESETN)
		known_reg && tdo_oe |-> (st_reg == ST_SHIFT_IR || st_reg == ST_SHIFT_DR))
		else $error("tdo driven outside shift");
	a_ir_capture_first: assert property (@(posedge tck) disable iff (!RESETN)
		ir_first && $past(st_reg) == ST_CAPTURE_IR |-> tdo_out)
		else $error("first instruction capture bit not one");
	a_ir_capture_rest: assert property (@(posedge tck) disable iff (!RESETN)
		ir_first && $past(st_reg) == ST_SHIFT_IR |-> !tdo_out)
		else $error("later instruction capture bit not zero");
	a_ir_four_bits: assert property (@(posedge tck) disable iff (!RESETN)
		known_reg && st_reg == ST_CAPTURE_IR |-> !tms [*4] ##1 tms)
		else $error("instruction shift length wrong");
	a_reset_five_high: assert property (@(posedge tck) disable iff (!RESETN)
		tms [*5] |=> !tdo_oe) else $error("five highs left tdo driven");

	c_shift_ir: cover property (@(posedge tck) st_reg == ST_SHIFT_IR);
	c_shift_dr: cover property (@(posedge tck) st_reg == ST_SHIFT_DR);
	c_five_high: cover property (@(posedge tck) tms [*5]);
	c_reset_pull: cover property (@(posedge CLK_SYS) rst_oe);
endmodule : tap_link_properties

// ---- test_jtag_tap_debug_access.sv ----
// Purpose: drives scan commands into the debugger end and checks the device through the link
// Assumes: both ends share one link interface
// Notes:   answers are checked from a queue of expected values, oldest first

`timescale 1ns/10ps

module test_jtag_tap_debug_access import tap_pkg::*; ;
	logic clk_sys;
	logic resetn, ext_rst_n, port_fuse, port_dis, dbg_fuse, lock1, lock2;
	logic pc_fetch, flow, step, dacc, cmd_valid, sys_rst_req;
	logic [ADDR_W-1:0] pc, daddr, a;
	cmd_kind_t cmd_kind;
	logic [4:0] cmd_len;
	logic [DR_W-1:0] cmd_data, d;
	wire cmd_ready, rsp_valid, rst_seen, pins_on, pull_on, dbg_on, brk;
	wire [DR_W-1:0] rsp_data;
	logic [DR_W-1:0] exp_q[$];
	logic [DR_W-1:0] msk_q[$];
	logic [31:0] seed = 32'h00011135;
	int miscompares = 0;
	int n_checks = 0;
	int cycles = 0;
	int i;
	logic [7:0] bp_ctl [4] = '{8'h01, 8'h02, 8'h20, 8'h24};
	logic [1:0] bp_slot [4] = '{2'h0, 2'h0, 2'h0, 2'h2};
	int miss_kind [4] = '{1, 0, 3, 2};

	tap_link_if tap_link_if_i (.ext_rst_n(ext_rst_n));
	tap_device tap_device_i (.link(tap_link_if_i), .CLK_SYS(clk_sys), .RESETN(resetn),
		.TEST_PORT_ENABLE_FUSE(port_fuse), .TEST_PORT_DISABLE_BIT(port_dis),
		.DEBUG_ENABLE_FUSE(dbg_fuse), .SECURITY_LOCK_BIT_ONE(lock1),
		.SECURITY_LOCK_BIT_TWO(lock2), .PC_FETCH(pc_fetch), .PC(pc), .FLOW_CHANGE(flow),
		.STEP_DONE(step), .DATA_ACCESS(dacc), .DATA_ADDR(daddr), .TAP_PINS_ACTIVE(pins_on),
		.TAP_PULLUP_EN(pull_on), .DEBUG_ACTIVE(dbg_on), .BREAK_REQ(brk));
	tap_debugger tap_debugger_i (.link(tap_link_if_i), .CLK_SYS(clk_sys), .RESETN(resetn),
		.CMD_VALID(cmd_valid), .CMD_KIND(cmd_kind), .CMD_LEN(cmd_len), .CMD_DATA(cmd_data),
		.CMD_READY(cmd_ready), .RSP_VALID(rsp_valid), .RSP_DATA(rsp_data),
		.SYS_RESET_REQ(sys_rst_req), .SYS_RESET_SEEN(rst_seen));
	tap_link_properties tap_link_properties_i (.CLK_SYS(clk_sys), .RESETN(resetn),
		.tck(tap_link_if_i.tck), .tms(tap_link_if_i.tms), .tdi(tap_link_if_i.tdi),
		.tdo_out(tap_link_if_i.tdo_out), .tdo_oe(tap_link_if_i.tdo_oe), .tdo(tap_link_if_i.tdo),
		.rst_oe(tap_link_if_i.rst_oe), .rst_line_n(tap_link_if_i.rst_line_n));

	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : rnd

	task automatic chk(input string what, input logic [DR_W-1:0] e, s, m);
		n_checks++;
		if (((s & m) ^ (e & m)) !== '0)
		begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", what, e & m, s);
		end
	endtask : chk

	task automatic chk1(input string what, input logic e, input logic s);
		chk(what, {17'h00000, e}, {17'h00000, s}, 18'h00001);
	endtask : chk1

	task report_and_stop;
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : report_and_stop

	// the command is held until the edge that takes it
	task automatic scan(input cmd_kind_t k, input logic [4:0] n, input logic [DR_W-1:0] v, e, m);
		exp_q.push_back(e);
		msk_q.push_back(m);
		@(posedge clk_sys);
		#1;
		{cmd_valid, cmd_kind, cmd_len, cmd_data} = {1'b1, k, n, v};
		do @(posedge clk_sys); while (cmd_ready !== 1'b1);
		#1;
		cmd_valid = 1'b0;
	endtask : scan

	task automatic ir(input logic [3:0] c, input logic [3:0] e);
		scan(CMD_IR, 5'h04, {14'h0000, c}, {14'h0000, e}, 18'h0000F);
	endtask : ir

	// the settle wait covers the write crossing into CLK_SYS
	task automatic drain;
		while (exp_q.size() != 0 || cmd_ready !== 1'b1) @(posedge clk_sys);
		repeat (8) @(posedge clk_sys);
		#1;
	endtask : drain

	task automatic pulse(input int k, input logic [ADDR_W-1:0] at);
		{pc, daddr} = {at, at};
		{flow, step, pc_fetch, dacc} = 4'h8 >> k;
		@(posedge clk_sys);
		#1;
		{flow, step, pc_fetch, dacc} = 4'h0;
		repeat (3) @(posedge clk_sys);
		#1;
	endtask : pulse

	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end

	always @(posedge clk_sys)
	begin
		cycles++;
		if (cycles == 40000)
		begin
			miscompares++;
			report_and_stop();
		end
		if (rsp_valid === 1'b1)
		begin
			if (exp_q.size() == 0)
				chk("unexpected answer", '0, '1, '1);
			else
				chk("answer data", exp_q.pop_front(), rsp_data, msk_q.pop_front());
		end
	end

	initial
	begin
		{resetn, ext_rst_n, port_fuse, port_dis, dbg_fuse, lock1, lock2} = 7'h34;
		{pc_fetch, flow, step, dacc, cmd_valid, sys_rst_req, pc, daddr} = '0;
		{cmd_kind, cmd_len, cmd_data} = {CMD_RESET, 5'h00, 18'h00000};
		repeat (3) @(posedge clk_sys);
		#1;
		resetn = 1'b1;
		scan(CMD_RESET, 5'h00, '0, '0, '0);
		d = rnd();
		scan(CMD_DR, LEN_BYTE, d, {10'h000, d[6:0], 1'b0}, 18'h000FF);
		ir(INSTR_BYPASS, 4'h1);
		scan(CMD_DR, LEN_BYPASS, '1, '0, 18'h00001);
		ir(DEBUG_INSTR_0, 4'h1);
		scan(CMD_DR, LEN_BP_ADDR, '0, '0, '0);
		ir(DEBUG_INSTR_1, 4'h1);
		for (i = 0; i < 3; i++)
		begin
			d = rnd();
			scan(CMD_DR, LEN_BYTE, {10'h000, d[7:0]}, '0, '0);
			scan(CMD_DR, LEN_BYTE, {10'h000, ~d[7:0]}, d, 18'h000FF);
		end
		drain();
		$display("test scan paths done");
		for (i = 0; i < 4; i++)
		begin
			{port_dis, port_fuse} = i[1:0];
			repeat (8) @(posedge clk_sys);
			#1;
			scan(CMD_RESET, 5'h00, '0, '0, '0);
			ir(INSTR_BYPASS, (i == 1) ? 4'h1 : 4'hF);
			drain();
			chk1("pins active", i == 1, pins_on);
			chk1("pull up", i[0], pull_on);
		end
		for (i = 0; i < 4; i++)
		begin
			{port_dis, port_fuse, dbg_fuse, lock1, lock2} = {2'b01, i != 0, i == 1, i == 2};
			d = rnd();
			scan(CMD_RESET, 5'h00, '0, '0, '0);
			ir(DEBUG_INSTR_2, 4'h1);
			scan(CMD_DR, LEN_BYTE, d, (i == 3) ? 18'h00001 : {10'h000, d[6:0], 1'b0},
				(i == 3) ? 18'h00001 : 18'h000FF);
			drain();
			chk1("debug active", i == 3, dbg_on);
		end
		$display("test gating done");
		for (i = 0; i < 4; i++)
		begin
			a = rnd();
			ir(DEBUG_INSTR_0, 4'h1);
			scan(CMD_DR, LEN_BP_ADDR, {bp_slot[i], a}, '0, '0);
			ir(DEBUG_INSTR_1, 4'h1);
			scan(CMD_DR, LEN_BYTE, {10'h000, bp_ctl[i]}, '0, '0);
			ir(DEBUG_INSTR_3, 4'h1);
			scan(CMD_DR, LEN_BYTE, 18'h00001, '0, '0);
			drain();
			chk1("break idle", 1'b0, brk);
			pulse(miss_kind[i], a);
			chk1("break on miss", 1'b0, brk);
			pulse(i, a);
			chk1("break on hit", 1'b1, brk);
			ir(DEBUG_INSTR_2, 4'h1);
			scan(CMD_DR, LEN_BYTE, '0, 18'h00003, 18'h00003);
		end
		drain();
		$display("test breakpoints done");
		sys_rst_req = 1'b1;
		repeat (6) @(posedge clk_sys);
		chk1("own pull", 1'b1, rst_seen);
		#1;
		sys_rst_req = 1'b0;
		repeat (6) @(posedge clk_sys);
		chk1("reset released", 1'b0, rst_seen);
		#1;
		ext_rst_n = 1'b0;
		repeat (6) @(posedge clk_sys);
		chk1("external reset", 1'b1, rst_seen);
		#1;
		ext_rst_n = 1'b1;
		$display("test system reset done");
		report_and_stop();
	end
endmodule : test_jtag_tap_debug_access
